// *** src/can_filter_config.sv ***
// Acceptance mask and filter control registers with frame matching logic.
// Assumes an AXI4-Lite master on CLK_I and frames presented on the same clock.
`timescale 1ns/1ps
module can_filter_config
(
   input  wire logic        CLK_I,
   input  wire logic        RST_I,
   input  wire logic [7:0]  AWADDR_I,
   input  wire logic        AWVALID_I,
   output logic             AWREADY_O,
   input  wire logic [31:0] WDATA_I,
   input  wire logic [3:0]  WSTRB_I,
   input  wire logic        WVALID_I,
   output logic             WREADY_O,
   output logic [1:0]       BRESP_O,
   output logic             BVALID_O,
   input  wire logic        BREADY_I,
   input  wire logic [7:0]  ARADDR_I,
   input  wire logic        ARVALID_I,
   output logic             ARREADY_O,
   output logic [31:0]      RDATA_O,
   output logic [1:0]       RRESP_O,
   output logic             RVALID_O,
   input  wire logic        RREADY_I,
   input  wire logic        FRAME_VALID_I,
   input  wire logic [28:0] FRAME_ID_I,
   input  wire logic        FRAME_EXTENDED_I,
   output logic             ACCEPT_O,
   output logic [4:0]       ACCEPT_FIFO_O,
   output logic [1:0]       ACCEPT_FILTER_O
);

   typedef enum {REG_CONTROL, REG_MASK, REG_FLTCON, REG_FLTID, REG_STATUS, REG_NONE} reg_kind_t;

   logic [31:0] controller_control_register;
   logic [31:0] acceptance_mask [can_filter_pkg::NUM_MASKS];
   logic [31:0] filter_control_0;
   logic [31:0] filter_id [can_filter_pkg::NUM_FILTERS];
   logic [7:0]  aw_addr;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        do_write;
   logic [7:0]  match_count;

   // Classifies an address; address bits 3:2 select the mask or filter and bits 1:0 must be zero.
   function automatic reg_kind_t decode(input logic [7:0] a);
      reg_kind_t k;
      k = REG_NONE;
      if (a == can_filter_pkg::OFF_CONTROL)
         k = REG_CONTROL;
      else if (a[7:4] == can_filter_pkg::OFF_MASK0[7:4] && a[1:0] == 2'h0)
         k = REG_MASK;
      else if (a == can_filter_pkg::OFF_FLTCON0)
         k = REG_FLTCON;
      else if (a[7:4] == can_filter_pkg::OFF_FLTID0[7:4] && a[1:0] == 2'h0)
         k = REG_FLTID;
      else if (a == can_filter_pkg::OFF_STATUS)
         k = REG_STATUS;
      return k;
   endfunction

   // Applies byte strobes and keeps unimplemented bits at zero.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [3:0] s, input logic [31:0] impl);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (s[b])
            r[b*8 +: 8] = d[b*8 +: 8];
      end
      return r & impl;
   endfunction

   // Write address and data are taken independently and paired before the response.
   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         AWREADY_O <= 1'b1;
         aw_addr   <= 8'h00;
      end
      else if (AWVALID_I && AWREADY_O)
      begin
         AWREADY_O <= 1'b0;
         aw_addr   <= AWADDR_I;
      end
      else if (BVALID_O && BREADY_I)
         AWREADY_O <= 1'b1;
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         WREADY_O <= 1'b1;
         w_data   <= can_filter_pkg::RESET_ZERO;
         w_strb   <= 4'h0;
      end
      else if (WVALID_I && WREADY_O)
      begin
         WREADY_O <= 1'b0;
         w_data   <= WDATA_I;
         w_strb   <= WSTRB_I;
      end
      else if (BVALID_O && BREADY_I)
         WREADY_O <= 1'b1;
   end

   assign do_write = !AWREADY_O && !WREADY_O && !BVALID_O;

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         BVALID_O <= 1'b0;
         BRESP_O  <= can_filter_pkg::RESP_OKAY;
      end
      else if (do_write)
      begin
         BVALID_O <= 1'b1;
         BRESP_O  <= (decode(aw_addr) == REG_NONE) ? can_filter_pkg::RESP_DECERR : can_filter_pkg::RESP_OKAY;
      end
      else if (BVALID_O && BREADY_I)
         BVALID_O <= 1'b0;
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         controller_control_register <= can_filter_pkg::RESET_ZERO;
      else if (do_write && decode(aw_addr) == REG_CONTROL)
         controller_control_register <= merge(controller_control_register, w_data, w_strb,
                                              can_filter_pkg::CONTROL_IMPL);
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         for (int m = 0; m < can_filter_pkg::NUM_MASKS; m++)
            acceptance_mask[m] <= can_filter_pkg::RESET_ZERO;
      end
      else if (do_write && decode(aw_addr) == REG_MASK
               && controller_control_register[can_filter_pkg::OPMODE_LSB +: 3] == can_filter_pkg::OPMODE_CONFIG)
         acceptance_mask[aw_addr[3:2]] <= merge(acceptance_mask[aw_addr[3:2]], w_data, w_strb,
                                                can_filter_pkg::MASK_IMPL);
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         filter_control_0 <= can_filter_pkg::RESET_ZERO;
      else if (do_write && decode(aw_addr) == REG_FLTCON)
      begin
         for (int f = 0; f < can_filter_pkg::NUM_FILTERS; f++)
         begin
            if (w_strb[f])
            begin
               filter_control_0[f*8 + can_filter_pkg::FLTEN_BIT] <= w_data[f*8 + can_filter_pkg::FLTEN_BIT];
               if (!filter_control_0[f*8 + can_filter_pkg::FLTEN_BIT])
                  filter_control_0[f*8 +: 7] <= w_data[f*8 +: 7] & can_filter_pkg::FLT_CFG_BITS[6:0];
            end
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         for (int f = 0; f < can_filter_pkg::NUM_FILTERS; f++)
            filter_id[f] <= can_filter_pkg::RESET_ZERO;
      end
      else if (do_write && decode(aw_addr) == REG_FLTID
               && !filter_control_0[aw_addr[3:2]*8 + can_filter_pkg::FLTEN_BIT])
         filter_id[aw_addr[3:2]] <= merge(filter_id[aw_addr[3:2]], w_data, w_strb, can_filter_pkg::FLTID_IMPL);
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         ARREADY_O <= 1'b1;
         RVALID_O  <= 1'b0;
         RDATA_O   <= can_filter_pkg::RESET_ZERO;
         RRESP_O   <= can_filter_pkg::RESP_OKAY;
      end
      else if (ARVALID_I && ARREADY_O)
      begin
         ARREADY_O <= 1'b0;
         RVALID_O  <= 1'b1;
         RRESP_O   <= can_filter_pkg::RESP_OKAY;
         case (decode(ARADDR_I))
            REG_CONTROL: RDATA_O <= controller_control_register;
            REG_MASK:    RDATA_O <= acceptance_mask[ARADDR_I[3:2]];
            REG_FLTCON:  RDATA_O <= filter_control_0;
            REG_FLTID:   RDATA_O <= filter_id[ARADDR_I[3:2]];
            REG_STATUS:  RDATA_O <= {16'h0000, match_count, ACCEPT_O, ACCEPT_FILTER_O, ACCEPT_FIFO_O};
            default:
            begin
               RDATA_O <= can_filter_pkg::RESET_ZERO;
               RRESP_O <= can_filter_pkg::RESP_DECERR;
            end
         endcase
      end
      else if (RVALID_O && RREADY_I)
      begin
         RVALID_O  <= 1'b0;
         ARREADY_O <= 1'b1;
      end
   end

   // Lowest-numbered matching filter wins when several match one frame.
   logic       next_accept;
   logic [4:0] next_fifo;
   logic [1:0] next_filter;

   always_comb
   begin
      logic [31:0] msk;
      logic [31:0] fid;
      logic [28:0] diff;
      logic [28:0] care;
      logic        hit;
      msk         = 32'h0000_0000;
      fid         = 32'h0000_0000;
      diff        = 29'h0000_0000;
      care        = 29'h0000_0000;
      hit         = 1'b0;
      next_accept = 1'b0;
      next_fifo   = 5'h00;
      next_filter = 2'h0;
      for (int f = can_filter_pkg::NUM_FILTERS - 1; f >= 0; f--)
      begin
         msk  = acceptance_mask[filter_control_0[f*8 + can_filter_pkg::MSEL_LSB +: 2]];
         fid  = filter_id[f];
         diff = FRAME_ID_I ^ {fid[can_filter_pkg::SID_LSB +: 11], fid[17:0]};
         care = {msk[can_filter_pkg::SID_LSB +: 11], FRAME_EXTENDED_I ? msk[17:0] : 18'h00000};
         hit  = ((diff & care) == 29'h0000_0000);
         if (msk[can_filter_pkg::IDTYPE_BIT] && (FRAME_EXTENDED_I != fid[can_filter_pkg::IDTYPE_BIT]))
            hit = 1'b0;
         if (hit && filter_control_0[f*8 + can_filter_pkg::FLTEN_BIT])
         begin
            next_accept = 1'b1;
            next_fifo   = filter_control_0[f*8 + can_filter_pkg::FSEL_LSB +: 5];
            next_filter = 2'(f);
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
      begin
         ACCEPT_O        <= 1'b0;
         ACCEPT_FIFO_O   <= 5'h00;
         ACCEPT_FILTER_O <= 2'h0;
      end
      else
      begin
         ACCEPT_O <= FRAME_VALID_I && next_accept;
         if (FRAME_VALID_I && next_accept)
         begin
            ACCEPT_FIFO_O   <= next_fifo;
            ACCEPT_FILTER_O <= next_filter;
         end
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I)
   begin
      if (RST_I)
         match_count <= 8'h00;
      else if (FRAME_VALID_I && next_accept)
         match_count <= match_count + 8'h01;
   end

endmodule // can_filter_config

// *** src/can_filter_pkg.sv ***
// Constants for the CAN acceptance filter configuration block.
// Assumes a 32-bit AXI4-Lite register bus and a same-clock frame source.
package can_filter_pkg;
   localparam int unsigned ADDR_W       = 8;
   localparam logic [7:0]  OFF_CONTROL  = 8'h00;
   localparam logic [7:0]  OFF_MASK0    = 8'h10;
   localparam logic [7:0]  OFF_FLTCON0  = 8'h20;
   localparam logic [7:0]  OFF_FLTID0   = 8'h30;
   localparam logic [7:0]  OFF_STATUS   = 8'h40;
   localparam int unsigned NUM_MASKS    = 4;
   localparam int unsigned NUM_FILTERS  = 4;
   localparam logic [31:0] RESET_ZERO   = 32'h0000_0000;
   localparam logic [31:0] MASK_IMPL    = 32'hffeb_ffff;
   localparam logic [31:0] FLTID_IMPL   = 32'hffeb_ffff;
   localparam logic [31:0] CONTROL_IMPL = 32'h00e0_0000;
   localparam int unsigned OPMODE_LSB   = 21;
   localparam logic [2:0]  OPMODE_CONFIG = 3'h4;
   localparam int unsigned SID_LSB      = 21;
   localparam int unsigned IDTYPE_BIT   = 19;
   localparam int unsigned FLTEN_BIT    = 7;
   localparam int unsigned MSEL_LSB     = 5;
   localparam int unsigned FSEL_LSB     = 0;
   localparam logic [7:0]  FLT_CFG_BITS = 8'h7f;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_DECERR  = 2'h3;
endpackage

// *** sim/can_filter_config_assertions.sv ***
// Bus handshake and frame acceptance checks for the filter block.
// Bound to the top module; sees only its ports.
`timescale 1ns/1ps
module can_filter_config_assertions
(
   input wire logic        CLK_I,
   input wire logic        RST_I,
   input wire logic        AWVALID_I,
   input wire logic        AWREADY_O,
   input wire logic        WVALID_I,
   input wire logic        WREADY_O,
   input wire logic        BVALID_O,
   input wire logic        BREADY_I,
   input wire logic        ARVALID_I,
   input wire logic        ARREADY_O,
   input wire logic [31:0] RDATA_O,
   input wire logic        RVALID_O,
   input wire logic        RREADY_I,
   input wire logic        FRAME_VALID_I,
   input wire logic        ACCEPT_O,
   input wire logic [4:0]  ACCEPT_FIFO_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   property p_accept_cause; ACCEPT_O |-> $past(FRAME_VALID_I); endproperty
   a_accept_cause: assert property (p_accept_cause) else $error("accept without frame");
   property p_fifo_moves; $changed(ACCEPT_FIFO_O) |-> ACCEPT_O; endproperty
   a_fifo_moves: assert property (p_fifo_moves) else $error("fifo changed without accept");
   property p_wr_answer; AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##[1:2] BVALID_O; endproperty
   a_wr_answer: assert property (p_wr_answer) else $error("write response missing");
   property p_b_hold; BVALID_O && !BREADY_I |=> BVALID_O; endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_b_done; BVALID_O && BREADY_I |=> !BVALID_O && AWREADY_O; endproperty
   a_b_done: assert property (p_b_done) else $error("write response not released");
   property p_rd_answer; ARVALID_I && ARREADY_O |=> RVALID_O && !ARREADY_O; endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read data late");
   property p_r_hold; RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O); endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data not held");
   property p_r_done; RVALID_O && RREADY_I |=> !RVALID_O; endproperty
   a_r_done: assert property (p_r_done) else $error("read data not released");
   c_write: cover property (BVALID_O && BREADY_I);
   c_read: cover property (RVALID_O && RREADY_I);
   c_accept: cover property (ACCEPT_O);
endmodule // can_filter_config_assertions

// *** sim/frame_source.sv ***
// Model of the receiver handing decoded frames to the filter block.
// Drives one-cycle frame strobes on the shared clock.
`timescale 1ns/1ps
module frame_source
(
   input  wire logic        clk_i,
   output logic             valid_o,
   output logic [28:0]      id_o,
   output logic             ext_o
);
   initial
   begin
      valid_o = 1'b0;
      id_o = 29'h0;
      ext_o = 1'b0;
   end
   // After each frame the lines show the inverse so stale values cannot match.
   task automatic send(input logic [28:0] id, input logic ext);
      @(posedge clk_i);
      valid_o <= 1'b1;
      id_o <= id;
      ext_o <= ext;
      @(posedge clk_i);
      valid_o <= 1'b0;
      id_o <= ~id;
      ext_o <= ~ext;
   endtask
endmodule // frame_source

// *** sim/tb_top.sv ***
// Self-checking bench for the CAN acceptance filter block.
// Drives AXI4-Lite and frames; the checker is bound below.
`timescale 1ns/1ps
module tb_top;
   logic        CLK_I = 1'b0, RST_I = 1'b1, AWVALID_I = 1'b0, WVALID_I = 1'b0;
   logic        BREADY_I = 1'b0, ARVALID_I = 1'b0, RREADY_I = 1'b0;
   logic [7:0]  AWADDR_I = 8'h00, ARADDR_I = 8'h00;
   logic [31:0] WDATA_I = 32'h0, RDATA_O;
   logic [3:0]  WSTRB_I = 4'hf;
   logic        FRAME_VALID_I, FRAME_EXTENDED_I, AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, ACCEPT_O;
   logic [28:0] FRAME_ID_I;
   logic [1:0]  BRESP_O, RRESP_O, ACCEPT_FILTER_O;
   logic [4:0]  ACCEPT_FIFO_O;
   logic [31:0] d;
   logic [1:0]  r;
   logic [1:0]  br;
   int          n_mismatch = 0, n_compared = 0;
   always #5 CLK_I = ~CLK_I;
   can_filter_config dut
   (
      .CLK_I            (CLK_I),
      .RST_I            (RST_I),
      .AWADDR_I         (AWADDR_I),
      .AWVALID_I        (AWVALID_I),
      .AWREADY_O        (AWREADY_O),
      .WDATA_I          (WDATA_I),
      .WSTRB_I          (WSTRB_I),
      .WVALID_I         (WVALID_I),
      .WREADY_O         (WREADY_O),
      .BRESP_O          (BRESP_O),
      .BVALID_O         (BVALID_O),
      .BREADY_I         (BREADY_I),
      .ARADDR_I         (ARADDR_I),
      .ARVALID_I        (ARVALID_I),
      .ARREADY_O        (ARREADY_O),
      .RDATA_O          (RDATA_O),
      .RRESP_O          (RRESP_O),
      .RVALID_O         (RVALID_O),
      .RREADY_I         (RREADY_I),
      .FRAME_VALID_I    (FRAME_VALID_I),
      .FRAME_ID_I       (FRAME_ID_I),
      .FRAME_EXTENDED_I (FRAME_EXTENDED_I),
      .ACCEPT_O         (ACCEPT_O),
      .ACCEPT_FIFO_O    (ACCEPT_FIFO_O),
      .ACCEPT_FILTER_O  (ACCEPT_FILTER_O)
   );
   frame_source src (.clk_i(CLK_I), .valid_o(FRAME_VALID_I), .id_o(FRAME_ID_I), .ext_o(FRAME_EXTENDED_I));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("CHECK FAILED %0t got %h expected %h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge CLK_I);
      AWADDR_I <= a;
      WDATA_I <= v;
      AWVALID_I <= 1'b1;
      WVALID_I <= 1'b1;
      do
      begin
         @(posedge CLK_I);
         if (AWREADY_O === 1'b1) aw = 1'b0;
         if (WREADY_O === 1'b1) w = 1'b0;
         AWVALID_I <= aw;
         WVALID_I <= w;
      end
      while (aw | w);
      @(posedge CLK_I);
      BREADY_I <= 1'b1;
      do @(posedge CLK_I); while (BVALID_O !== 1'b1);
      br = BRESP_O;
      BREADY_I <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge CLK_I);
      ARADDR_I <= a;
      ARVALID_I <= 1'b1;
      do @(posedge CLK_I); while (ARREADY_O !== 1'b1);
      ARVALID_I <= 1'b0;
      @(posedge CLK_I);
      RREADY_I <= 1'b1;
      do @(posedge CLK_I); while (RVALID_O !== 1'b1);
      d = RDATA_O;
      r = RRESP_O;
      RREADY_I <= 1'b0;
   endtask
   task automatic frm(input logic [28:0] id, input logic x, input logic e, input logic [6:0] f);
      src.send(id, x);
      #1;
      chk({31'h0, ACCEPT_O}, {31'h0, e});
      if (e) chk({25'h0, ACCEPT_FILTER_O, ACCEPT_FIFO_O}, {25'h0, f});
   endtask
   task automatic t_mask_lock;
      rd(can_filter_pkg::OFF_FLTCON0);
      chk(d, 32'h0);
      wr(can_filter_pkg::OFF_MASK0, 32'hffff_ffff);
      chk({30'h0, br}, {30'h0, can_filter_pkg::RESP_OKAY});
      rd(can_filter_pkg::OFF_MASK0);
      chk(d, 32'h0);
      wr(can_filter_pkg::OFF_CONTROL, 32'h0080_0000);
      wr(can_filter_pkg::OFF_MASK0, 32'hffff_ffff);
      rd(can_filter_pkg::OFF_MASK0);
      chk(d, 32'hffeb_ffff);
      rd(8'h80);
      chk({r, d[29:0]}, {2'h3, 30'h0});
      wr(8'h80, 32'hffff_ffff);
      chk({30'h0, br}, {30'h0, can_filter_pkg::RESP_DECERR});
   endtask
   task automatic t_match;
      wr(8'h14, 32'h0000_0001);
      wr(can_filter_pkg::OFF_CONTROL, 32'h0);
      wr(can_filter_pkg::OFF_FLTCON0, 32'h0000_00bf);
      frm(29'h1fff_fffe, 1'b1, 1'b1, {2'h0, 5'h1f});
      frm(29'h1fff_ffff, 1'b1, 1'b0, 7'h0);
   endtask
   task automatic t_enabled_lock;
      wr(can_filter_pkg::OFF_FLTCON0, 32'h00e3_0080);
      rd(can_filter_pkg::OFF_FLTCON0);
      chk(d, 32'h00e3_00bf);
      frm(29'h1fff_ffff, 1'b1, 1'b1, {2'h2, 5'h03});
      wr(can_filter_pkg::OFF_FLTID0, 32'hffff_ffff);
      rd(can_filter_pkg::OFF_FLTID0);
      chk(d, 32'h0);
   endtask
   task automatic t_id_type;
      wr(can_filter_pkg::OFF_CONTROL, 32'h0080_0000);
      wr(8'h14, 32'h0008_0001);
      wr(can_filter_pkg::OFF_CONTROL, 32'h0);
      frm(29'h1fff_fffe, 1'b1, 1'b1, {2'h2, 5'h03});
      frm(29'h1fff_fffe, 1'b0, 1'b1, {2'h0, 5'h1f});
      rd(can_filter_pkg::OFF_STATUS);
      chk(d, 32'h0000_041f);
   endtask
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge CLK_I);
      RST_I <= 1'b0;
      t_mask_lock;
      t_match;
      t_enabled_lock;
      t_id_type;
      tally_and_finish;
   end
   initial
   begin
      #100000;
      n_mismatch++;
      tally_and_finish;
   end
endmodule // tb_top
bind can_filter_config can_filter_config_assertions u_chk
(
   .CLK_I         (CLK_I),
   .RST_I         (RST_I),
   .AWVALID_I     (AWVALID_I),
   .AWREADY_O     (AWREADY_O),
   .WVALID_I      (WVALID_I),
   .WREADY_O      (WREADY_O),
   .BVALID_O      (BVALID_O),
   .BREADY_I      (BREADY_I),
   .ARVALID_I     (ARVALID_I),
   .ARREADY_O     (ARREADY_O),
   .RDATA_O       (RDATA_O),
   .RVALID_O      (RVALID_O),
   .RREADY_I      (RREADY_I),
   .FRAME_VALID_I (FRAME_VALID_I),
   .ACCEPT_O      (ACCEPT_O),
   .ACCEPT_FIFO_O (ACCEPT_FIFO_O)
);
